/* File: bench/pmi_partner.sv */
`timescale 1ns/10ps
// far-side mac or phy: drives the link pins on the link clock
module pmi_partner (
    input  wire logic       link_clk,
    output logic            tx_en,
    output logic            tx_err,
    output logic [7:0]      tx_data,
    input  wire logic       rx_valid,
    input  wire logic       rx_error,
    input  wire logic [7:0] rx_data,
    output logic            col,
    output logic            crs
);
    logic [8:0] rx_q[$];
    initial begin
        tx_en = 1'b0;
        tx_err = 1'b0;
        tx_data = 8'h00;
        col = 1'b0;
        crs = 1'b0;
    end
    always @(posedge link_clk) begin
        if (rx_valid) begin
            rx_q.push_back({rx_error, rx_data});
        end
    end
    task automatic send(input logic [8:0] w);
        @(posedge link_clk);
        tx_en <= 1'b1;
        tx_err <= w[8];
        tx_data <= w[7:0];
    endtask
    // released data toggles so stale bytes never look like data
    task automatic idle();
        @(posedge link_clk);
        tx_en <= 1'b0;
        tx_err <= 1'b0;
        tx_data <= ~tx_data;
    endtask
    task automatic status(input logic c, input logic s);
        @(posedge link_clk);
        col <= c;
        crs <= s;
    endtask
endmodule

/* File: bench/pmi_port_tb.sv */
`timescale 1ns/10ps
module pmi_port_tb;
    logic       clk = 1'b0;
    logic       link_clk = 1'b0;
    logic       rst = 1'b1;
    logic       strap = 1'b1;
    logic       gig = 1'b1;
    logic       fdx = 1'b1;
    logic       crr = 1'b0;
    logic       ctv = 1'b0;
    logic       cte = 1'b0;
    logic [7:0] ctd = 8'h00;
    logic [7:0] tx_data, rx_data, crd;
    logic       tx_en, tx_err, p_col, p_crs, txc, txc_oe_n, rxc;
    logic       rxc_oe_n, grxc, col_o, col_oe_n, crs_o, crs_oe_n;
    logic       rx_valid, rx_error, crv, cre, crend, ctr;
    logic       ccol, ccar, covr, saw_full, saw_col, saw_car;
    logic [2:0] ccfg;
    int         fail_count = 0;
    int         samples_checked = 0;
    wire        col_w = col_oe_n ? p_col : col_o;
    wire        crs_w = crs_oe_n ? p_crs : crs_o;

    always #2.5 clk = ~clk;
    initial begin
        #2.3;
        forever #7.5 link_clk = ~link_clk;
    end

    pmi_port i_pmi_port (.clk(clk), .rst(rst), .link_clk(link_clk),
        .role_select_strap(strap), .speed_gig(gig), .duplex_full(fdx),
        .port_tx_enable(tx_en), .port_tx_error(tx_err),
        .port_tx_data(tx_data), .port_tx_clock_o(txc),
        .port_tx_clock_oe_n(txc_oe_n), .port_rx_clock_o(rxc),
        .port_rx_clock_oe_n(rxc_oe_n), .port_gig_rx_clock(grxc),
        .port_collision_i(col_w), .port_collision_o(col_o),
        .port_collision_oe_n(col_oe_n), .port_carrier_sense_i(crs_w),
        .port_carrier_sense_o(crs_o), .port_carrier_sense_oe_n(crs_oe_n),
        .port_rx_valid(rx_valid), .port_rx_error(rx_error),
        .port_rx_data(rx_data), .core_rx_valid(crv), .core_rx_ready(crr),
        .core_rx_data(crd), .core_rx_error(cre), .core_rx_end(crend),
        .core_tx_valid(ctv), .core_tx_ready(ctr), .core_tx_data(ctd),
        .core_tx_error(cte), .core_collision(ccol), .core_carrier(ccar),
        .core_overrun(covr), .core_config(ccfg));
    pmi_partner i_pmi_partner (.link_clk(link_clk), .tx_en(tx_en),
        .tx_err(tx_err), .tx_data(tx_data), .rx_valid(rx_valid),
        .rx_error(rx_error), .rx_data(rx_data), .col(p_col), .crs(p_crs));

    task automatic chk_word(input logic [9:0] got, input logic [9:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_word({9'h000, got}, {9'h000, exp});
    endtask
    task automatic end_of_test();
        $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic do_reset(input logic s, input logic g, input logic f);
        @(posedge clk);
        rst <= 1'b1;
        strap <= s;
        gig <= g;
        fdx <= f;
        // held long enough for four link clock edges as well
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        strap <= ~s;
        repeat (4) @(posedge link_clk);
        @(negedge clk);
        chk_word({7'h00, ccfg}, {7'h00, f, g, s});
    endtask
    task automatic pull(input logic [9:0] exp);
        int n;
        n = 0;
        while (crv !== 1'b1 && n < 400) begin
            @(negedge clk);
            n++;
        end
        chk_bit(crv, 1'b1);
        chk_word({crend, cre, crd}, exp);
        @(posedge clk);
        crr <= 1'b1;
        @(posedge clk);
        crr <= 1'b0;
        @(negedge clk);
    endtask
    task automatic push(input logic [8:0] w);
        int n;
        n = 0;
        @(posedge clk);
        ctv <= 1'b1;
        cte <= w[8];
        ctd <= w[7:0];
        @(negedge clk);
        while (ctr !== 1'b1 && n < 400) begin
            saw_full = 1'b1;
            @(negedge clk);
            n++;
        end
        chk_bit(ctr, 1'b1);
    endtask
    task automatic cframe(input logic [8:0] w[$]);
        i_pmi_partner.rx_q.delete();
        foreach (w[i]) push(w[i]);
        @(posedge clk);
        ctv <= 1'b0;
    endtask
    task automatic lframe(input logic [8:0] w[$]);
        foreach (w[i]) i_pmi_partner.send(w[i]);
        i_pmi_partner.idle();
    endtask
    task automatic rx_expect(input logic [8:0] w[$]);
        repeat (12) @(posedge link_clk);
        @(negedge clk);
        chk_word(10'(i_pmi_partner.rx_q.size()), 10'(w.size()));
        foreach (w[i]) begin
            if (i < i_pmi_partner.rx_q.size()) begin
                chk_word({1'b0, i_pmi_partner.rx_q[i]}, {1'b0, w[i]});
            end
        end
    endtask
    task automatic mon();
        repeat (150) begin
            @(negedge clk);
            saw_col = saw_col | (ccol === 1'b1);
            saw_car = saw_car | (ccar === 1'b1);
        end
    endtask

    task automatic t_gig_phy();
        do_reset(1'b1, 1'b1, 1'b1);
        chk_bit(txc_oe_n, 1'b1);
        chk_bit(col_oe_n, 1'b0);
        chk_bit(crs_oe_n, 1'b0);
        saw_full = 1'b0;
        saw_col = 1'b0;
        saw_car = 1'b0;
        fork
            lframe('{9'h055, 9'h1a3, 9'h0ff});
            begin
                pull(10'h055);
                pull(10'h1a3);
                pull(10'h0ff);
                pull(10'h200);
            end
            cframe('{9'h0c3, 9'h13c, 9'h000, 9'h0e7, 9'h15a});
            mon();
        join
        rx_expect('{9'h0c3, 9'h13c, 9'h000, 9'h0e7,
                    9'h15a});
        chk_bit(saw_col, 1'b0);
        chk_bit(saw_car, 1'b1);
        chk_bit(saw_full, 1'b1);
        chk_bit(covr, 1'b0);
        // nobody drains: four words fit, the end marker is lost
        lframe('{9'h011, 9'h022, 9'h033, 9'h044});
        repeat (20) @(negedge clk);
        chk_bit(covr, 1'b1);
        pull(10'h011);
        pull(10'h022);
        pull(10'h033);
        pull(10'h044);
    endtask
    task automatic t_mii_phy();
        do_reset(1'b1, 1'b0, 1'b0);
        chk_bit(txc_oe_n, 1'b0);
        chk_bit(rxc_oe_n, 1'b0);
        chk_bit(txc, link_clk);
        chk_bit(rxc, link_clk);
        fork
            lframe('{9'h005, 9'h00a, 9'h00c, 9'h103, 9'h007});
            begin
                pull(10'h0a5);
                pull(10'h13c);
                pull(10'h200);
            end
        join
        cframe('{9'h03c, 9'h081});
        rx_expect('{9'h00c, 9'h003, 9'h001, 9'h008});
        saw_col = 1'b0;
        fork
            cframe('{9'h011, 9'h022, 9'h033, 9'h044, 9'h055, 9'h066});
            begin
                repeat (4) @(posedge link_clk);
                lframe('{9'h001, 9'h002, 9'h003, 9'h004, 9'h005, 9'h006});
            end
            mon();
        join
        chk_bit(saw_col, 1'b1);
    endtask
    task automatic t_mac(input logic g);
        do_reset(1'b0, g, 1'b1);
        chk_bit(col_oe_n, 1'b1);
        chk_bit(crs_oe_n, 1'b1);
        chk_bit(txc_oe_n, 1'b1);
        chk_bit(rxc_oe_n, 1'b1);
        chk_bit(grxc, link_clk);
        i_pmi_partner.status(1'b1, 1'b1);
        repeat (20) @(negedge clk);
        chk_bit(ccar, 1'b1);
        chk_bit(ccol, 1'b1);
        i_pmi_partner.status(1'b0, 1'b0);
        fork
            lframe('{9'h0e1, 9'h01e});
            begin
                pull(g ? 10'h0e1 : 10'h0e1);
                if (g) begin
                    pull(10'h01e);
                end
                pull(10'h200);
            end
        join
    endtask

    initial begin
        t_gig_phy();
        t_mii_phy();
        t_mac(1'b1);
        t_mac(1'b0);
        end_of_test();
    end
    initial begin
        #150000;
        fail_count++;
        end_of_test();
    end
endmodule

/* File: verilog/pmi_pkg.sv */
package pmi_pkg;
    // widths
    localparam int DATA_W = 8;
    localparam int NIB_W  = 4;
    localparam int ING_W  = 10;
    localparam int EGR_W  = 9;
    // field positions inside buffer words
    localparam int ING_ERR_BIT = 8;
    localparam int ING_END_BIT = 9;
    localparam int EGR_ERR_BIT = 8;
    // captured configuration: positions and value after reset
    localparam int CFG_W    = 3;
    localparam int CFG_ROLE = 0;
    localparam int CFG_GIG  = 1;
    localparam int CFG_FDX  = 2;
    localparam logic [CFG_W-1:0] CFG_RST = 3'h0;
    // strap level that selects the phy role (faces an external mac)
    localparam logic ROLE_PHY = 1'b1;
    // synchroniser depths in cycles
    localparam int PIN_SYNC_STAGES  = 3;
    localparam int LINK_RST_STAGES  = 3;
    // nominal link clock rates, supplied on the link clock port, then the core clock rate
    localparam int MII_10_CLK_HZ  = 2_500_000;
    localparam int MII_100_CLK_HZ = 25_000_000;
    localparam int GMII_CLK_HZ    = 125_000_000;
    localparam int CORE_CLK_HZ    = 200_000_000;

    typedef enum logic [2:0] {
        EGR_IDLE   = 3'b001,
        EGR_FIRST  = 3'b010,
        EGR_SECOND = 3'b100
    } pmi_egr_state_t;
endpackage

/* File: verilog/pmi_port.sv */
`timescale 1ns/10ps
// Overview of operation
// - one strap picks phy or mac role for both 4-bit and 8-bit links
// - 4-bit phy role: tx pins in; clocks, col, crs and rx pins out
// - 4-bit mac role: rx pins feed phy; clocks, col, crs come in
// - 4-bit link moves one nibble per clock, quarter of bit rate
// - transmit direction carries valid qualifier and error flag per word
// - receive direction carries valid qualifier and error indicator
// - in half duplex collision reports overlap while transmitting
// - 8-bit phy role: tx pins and gig tx clock in, 4-bit tx and rx clock pins released, rest driven out
// - 8-bit mac role: gig rx clock and rx pins out, col and crs in
// - 8-bit link carries one byte per clock, up to one gigabit
// - gigabit is full duplex only; collision only at lower speeds
// - link clock is 2.5 or 25 MHz for 4-bit, 125 MHz for 8-bit

// four-entry buffer between clock domains, gray pointers of three bits;
// the pointer round trip through both synchronisers lasts about four link
// words, so two entries would drop bytes inside every gigabit frame
module pmi_afifo #(
    parameter int W = 8
) (
    input  wire logic         wclk,
    input  wire logic         wrst,
    input  wire logic         wvalid,
    output logic              wready,
    input  wire logic [W-1:0] wdata,
    input  wire logic         rclk,
    input  wire logic         rrst,
    output logic              rvalid,
    input  wire logic         rready,
    output logic [W-1:0]      rdata
);
    logic [W-1:0] mem [0:3];
    logic [2:0]   wbin_reg;
    logic [2:0]   rbin_reg;
    logic [2:0]   wgray;
    logic [2:0]   rgray;
    logic [2:0]   rg_s1_reg;
    logic [2:0]   rg_s2_reg;
    logic [2:0]   wg_s1_reg;
    logic [2:0]   wg_s2_reg;

    assign wgray  = wbin_reg ^ {1'b0, wbin_reg[2:1]};
    assign rgray  = rbin_reg ^ {1'b0, rbin_reg[2:1]};
    // full means the two top gray bits are inverted and the last agrees
    assign wready = (wgray != {~rg_s2_reg[2:1], rg_s2_reg[0]});
    assign rvalid = (rgray != wg_s2_reg);
    assign rdata  = mem[rbin_reg[1:0]];

    always_ff @(posedge wclk) begin
        if (wvalid && wready) begin
            mem[wbin_reg[1:0]] <= wdata;
        end
    end

    always_ff @(posedge wclk) begin
        if (wrst) begin
            wbin_reg <= 3'h0;
        end else if (wvalid && wready) begin
            wbin_reg <= wbin_reg + 3'h1;
        end
    end

    always_ff @(posedge rclk) begin
        if (rrst) begin
            rbin_reg <= 3'h0;
        end else if (rvalid && rready) begin
            rbin_reg <= rbin_reg + 3'h1;
        end
    end

    always_ff @(posedge wclk) begin
        if (wrst) begin
            rg_s1_reg <= 3'h0;
            rg_s2_reg <= 3'h0;
        end else begin
            rg_s1_reg <= rgray;
            rg_s2_reg <= rg_s1_reg;
        end
    end

    always_ff @(posedge rclk) begin
        if (rrst) begin
            wg_s1_reg <= 3'h0;
            wg_s2_reg <= 3'h0;
        end else begin
            wg_s1_reg <= wgray;
            wg_s2_reg <= wg_s1_reg;
        end
    end
endmodule

module pmi_port (
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire logic                       link_clk,
    input  wire logic                       role_select_strap,
    input  wire logic                       speed_gig,
    input  wire logic                       duplex_full,
    input  wire logic                       port_tx_enable,
    input  wire logic                       port_tx_error,
    input  wire logic [pmi_pkg::DATA_W-1:0] port_tx_data,
    output logic                            port_tx_clock_o,
    output logic                            port_tx_clock_oe_n,
    output logic                            port_rx_clock_o,
    output logic                            port_rx_clock_oe_n,
    output logic                            port_gig_rx_clock,
    input  wire logic                       port_collision_i,
    output logic                            port_collision_o,
    output logic                            port_collision_oe_n,
    input  wire logic                       port_carrier_sense_i,
    output logic                            port_carrier_sense_o,
    output logic                            port_carrier_sense_oe_n,
    output logic                            port_rx_valid,
    output logic                            port_rx_error,
    output logic [pmi_pkg::DATA_W-1:0]      port_rx_data,
    output logic                            core_rx_valid,
    input  wire logic                       core_rx_ready,
    output logic [pmi_pkg::DATA_W-1:0]      core_rx_data,
    output logic                            core_rx_error,
    output logic                            core_rx_end,
    input  wire logic                       core_tx_valid,
    output logic                            core_tx_ready,
    input  wire logic [pmi_pkg::DATA_W-1:0] core_tx_data,
    input  wire logic                       core_tx_error,
    output logic                            core_collision,
    output logic                            core_carrier,
    output logic                            core_overrun,
    output logic [pmi_pkg::CFG_W-1:0]       core_config
);
    localparam int PS = pmi_pkg::PIN_SYNC_STAGES;
    localparam int LS = pmi_pkg::LINK_RST_STAGES;

    // ---------------- core clock domain
    logic [PS-1:0]              strap_sync_reg;
    logic [PS-1:0]              col_sync_reg;
    logic [PS-1:0]              crs_sync_reg;
    logic [pmi_pkg::CFG_W-1:0]  cfg_reg;
    logic [pmi_pkg::ING_W-1:0]  ing_rdata;
    logic                       ovr_s1_reg;
    logic                       ovr_s2_reg;
    logic                       ovr_reg;

    // pin synchronisers carry no reset so they keep sampling in reset
    always_ff @(posedge clk) begin
        strap_sync_reg <= {strap_sync_reg[PS-2:0], role_select_strap};
        col_sync_reg   <= {col_sync_reg[PS-2:0], port_collision_i};
        crs_sync_reg   <= {crs_sync_reg[PS-2:0], port_carrier_sense_i};
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            if (strap_sync_reg[PS-1] == strap_sync_reg[PS-2]) begin
                cfg_reg <= {duplex_full, speed_gig,
                            strap_sync_reg[PS-1] == pmi_pkg::ROLE_PHY};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            core_collision <= 1'b0;
            core_carrier   <= 1'b0;
        end else begin
            if (col_sync_reg[PS-1] == col_sync_reg[PS-2]) begin
                core_collision <= col_sync_reg[PS-1];
            end
            if (crs_sync_reg[PS-1] == crs_sync_reg[PS-2]) begin
                core_carrier <= crs_sync_reg[PS-1];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ovr_s1_reg <= 1'b0;
            ovr_s2_reg <= 1'b0;
        end else begin
            ovr_s1_reg <= ovr_reg;
            ovr_s2_reg <= ovr_s1_reg;
        end
    end

    assign core_overrun  = ovr_s2_reg;
    assign core_config   = cfg_reg;
    assign core_rx_data  = ing_rdata[pmi_pkg::DATA_W-1:0];
    assign core_rx_error = ing_rdata[pmi_pkg::ING_ERR_BIT];
    assign core_rx_end   = ing_rdata[pmi_pkg::ING_END_BIT];

    // ---------------- link clock domain
    logic [LS-1:0]              lrst_reg;
    logic                       lrst;
    logic [pmi_pkg::CFG_W-1:0]  cfg_l1_reg;
    logic [pmi_pkg::CFG_W-1:0]  cfg_l2_reg;
    logic                       role_phy;
    logic                       gig;
    logic                       fdx;
    logic                       en_reg;
    logic                       en_d_reg;
    logic                       er_reg;
    logic [pmi_pkg::DATA_W-1:0] d_reg;
    logic                       half_reg;
    logic [pmi_pkg::NIB_W-1:0]  low_reg;
    logic                       low_err_reg;
    logic                       ing_wvalid;
    logic                       ing_wready;
    logic [pmi_pkg::ING_W-1:0]  ing_wdata;
    logic                       egr_rvalid;
    logic                       egr_pop;
    logic [pmi_pkg::EGR_W-1:0]  egr_rdata;
    logic [pmi_pkg::NIB_W-1:0]  hold_reg;
    logic                       hold_err_reg;
    logic                       take_new;
    pmi_pkg::pmi_egr_state_t    egr_state_reg;

    // link logic is held in reset a few link edges past the core reset,
    // long enough for the captured configuration to settle over there
    always_ff @(posedge link_clk) begin
        lrst_reg   <= {lrst_reg[LS-2:0], rst};
        cfg_l1_reg <= cfg_reg;
        cfg_l2_reg <= cfg_l1_reg;
    end

    assign lrst     = |lrst_reg[LS-1:1];
    assign role_phy = cfg_l2_reg[pmi_pkg::CFG_ROLE];
    assign gig      = cfg_l2_reg[pmi_pkg::CFG_GIG];
    assign fdx      = cfg_l2_reg[pmi_pkg::CFG_FDX];

    // the 4-bit phy role forwards the link reference on the tx and rx clock
    // pins, which are released otherwise; port_gig_rx_clock is driven in every role
    assign port_tx_clock_o   = link_clk;
    assign port_rx_clock_o   = link_clk;
    assign port_gig_rx_clock = link_clk;

    always_ff @(posedge link_clk) begin
        if (lrst) begin
            port_tx_clock_oe_n      <= 1'b1;
            port_rx_clock_oe_n      <= 1'b1;
            port_collision_oe_n     <= 1'b1;
            port_carrier_sense_oe_n <= 1'b1;
        end else begin
            port_tx_clock_oe_n      <= ~role_phy | gig;
            port_rx_clock_oe_n      <= ~role_phy | gig;
            port_collision_oe_n     <= ~role_phy;
            port_carrier_sense_oe_n <= ~role_phy;
        end
    end

    // tx pins are synchronous to link_clk, one register stage suffices
    always_ff @(posedge link_clk) begin
        if (lrst) begin
            en_reg   <= 1'b0;
            en_d_reg <= 1'b0;
            er_reg   <= 1'b0;
            d_reg    <= 8'h00;
        end else begin
            en_reg   <= port_tx_enable;
            en_d_reg <= en_reg;
            er_reg   <= port_tx_error;
            d_reg    <= port_tx_data;
        end
    end

    always_ff @(posedge link_clk) begin
        if (lrst) begin
            port_collision_o     <= 1'b0;
            port_carrier_sense_o <= 1'b0;
        end else begin
            port_carrier_sense_o <= en_reg | port_rx_valid;
            port_collision_o     <= en_reg & port_rx_valid & ~gig & ~fdx;
        end
    end

    // ingress: bytes pass through, nibbles pair low first; an odd
    // trailing nibble is dropped and the frame end is a marker word
    always_comb begin
        ing_wvalid = 1'b0;
        ing_wdata  = '0;
        if (en_d_reg && !en_reg) begin
            ing_wvalid = 1'b1;
            ing_wdata[pmi_pkg::ING_END_BIT] = 1'b1;
        end else if (en_reg && gig) begin
            ing_wvalid = 1'b1;
            ing_wdata  = {1'b0, er_reg, d_reg};
        end else if (en_reg && half_reg) begin
            ing_wvalid = 1'b1;
            ing_wdata  = {1'b0, er_reg | low_err_reg,
                          d_reg[pmi_pkg::NIB_W-1:0], low_reg};
        end
    end

    always_ff @(posedge link_clk) begin
        if (lrst) begin
            half_reg    <= 1'b0;
            low_reg     <= 4'h0;
            low_err_reg <= 1'b0;
        end else if (en_reg && !gig) begin
            half_reg    <= ~half_reg;
            low_reg     <= d_reg[pmi_pkg::NIB_W-1:0];
            low_err_reg <= er_reg;
        end else begin
            half_reg <= 1'b0;
        end
    end

    // the link cannot be stalled, so a word meeting a full buffer is lost
    always_ff @(posedge link_clk) begin
        if (lrst) begin
            ovr_reg <= 1'b0;
        end else if (ing_wvalid && !ing_wready) begin
            ovr_reg <= 1'b1;
        end
    end

    pmi_afifo #(.W(pmi_pkg::ING_W)) u_ing (
        .wclk   (link_clk),
        .wrst   (lrst),
        .wvalid (ing_wvalid),
        .wready (ing_wready),
        .wdata  (ing_wdata),
        .rclk   (clk),
        .rrst   (rst),
        .rvalid (core_rx_valid),
        .rready (core_rx_ready),
        .rdata  (ing_rdata)
    );

    pmi_afifo #(.W(pmi_pkg::EGR_W)) u_egr (
        .wclk   (clk),
        .wrst   (rst),
        .wvalid (core_tx_valid),
        .wready (core_tx_ready),
        .wdata  ({core_tx_error, core_tx_data}),
        .rclk   (link_clk),
        .rrst   (lrst),
        .rvalid (egr_rvalid),
        .rready (egr_pop),
        .rdata  (egr_rdata)
    );

    // egress: a gap in the buffer ends the frame on the rx pins, so the
    // core must keep pace for a whole frame
    assign take_new = (egr_state_reg != pmi_pkg::EGR_FIRST) || gig;
    assign egr_pop  = take_new && egr_rvalid;

    always_ff @(posedge link_clk) begin
        if (lrst) begin
            egr_state_reg <= pmi_pkg::EGR_IDLE;
            port_rx_valid <= 1'b0;
            port_rx_error <= 1'b0;
            port_rx_data  <= 8'h00;
            hold_reg      <= 4'h0;
            hold_err_reg  <= 1'b0;
        end else begin
            case (egr_state_reg)
                pmi_pkg::EGR_IDLE, pmi_pkg::EGR_FIRST,
                pmi_pkg::EGR_SECOND: begin
                    if (!take_new) begin
                        egr_state_reg <= pmi_pkg::EGR_SECOND;
                        port_rx_data  <= {4'h0, hold_reg};
                        port_rx_error <= hold_err_reg;
                    end else if (egr_rvalid) begin
                        egr_state_reg <= pmi_pkg::EGR_FIRST;
                        port_rx_valid <= 1'b1;
                        port_rx_error <= egr_rdata[pmi_pkg::EGR_ERR_BIT];
                        port_rx_data  <= gig ? egr_rdata[7:0]
                                       : {4'h0, egr_rdata[3:0]};
                        hold_reg      <= egr_rdata[7:4];
                        hold_err_reg  <= egr_rdata[pmi_pkg::EGR_ERR_BIT];
                    end else begin
                        egr_state_reg <= pmi_pkg::EGR_IDLE;
                        port_rx_valid <= 1'b0;
                        port_rx_error <= 1'b0;
                        port_rx_data  <= 8'h00;
                    end
                end
                default: begin
                    egr_state_reg <= pmi_pkg::EGR_IDLE;
                    port_rx_valid <= 1'b0;
                end
            endcase
        end
    end

    // ---------------- checks
    property p_cfg_fixed;
        @(posedge clk) disable iff (rst) $stable(cfg_reg);
    endproperty
    a_cfg_fixed: assert property (p_cfg_fixed)
        else $error("configuration changed outside reset");

    property p_mac_release;
        @(posedge link_clk) disable iff (lrst)
        !role_phy |=> port_collision_oe_n && port_carrier_sense_oe_n
                      && port_tx_clock_oe_n && port_rx_clock_oe_n;
    endproperty
    a_mac_release: assert property (p_mac_release)
        else $error("mac role drives a partner-owned pin");

    property p_phy_drive;
        @(posedge link_clk) disable iff (lrst)
        role_phy ##1 role_phy |-> !port_collision_oe_n
                                  && !port_carrier_sense_oe_n;
    endproperty
    a_phy_drive: assert property (p_phy_drive)
        else $error("phy role does not drive status pins");

    property p_gig_no_col;
        @(posedge link_clk) disable iff (lrst)
        gig ##1 gig |-> !port_collision_o;
    endproperty
    a_gig_no_col: assert property (p_gig_no_col)
        else $error("collision raised at gigabit");

    property p_col_cause;
        @(posedge link_clk) disable iff (lrst)
        (!gig && !fdx && en_reg && port_rx_valid) |=> port_collision_o;
    endproperty
    a_col_cause: assert property (p_col_cause)
        else $error("half duplex overlap not reported");

    property p_nib_upper;
        @(posedge link_clk) disable iff (lrst)
        (!gig && port_rx_valid) ##1 !gig |-> port_rx_data[7:4] == 4'h0;
    endproperty
    a_nib_upper: assert property (p_nib_upper)
        else $error("nibble mode drives upper data bits");

    sequence s_first_nib;
        !gig && egr_state_reg == pmi_pkg::EGR_FIRST;
    endsequence
    property p_nib_pair;
        @(posedge link_clk) disable iff (lrst)
        s_first_nib |=> egr_state_reg == pmi_pkg::EGR_SECOND
                        && port_rx_valid;
    endproperty
    a_nib_pair: assert property (p_nib_pair)
        else $error("second nibble not sent");

    property p_err_valid;
        @(posedge link_clk) disable iff (lrst)
        port_rx_error |-> port_rx_valid;
    endproperty
    a_err_valid: assert property (p_err_valid)
        else $error("receive error without valid");

    property p_gig_push;
        @(posedge link_clk) disable iff (lrst)
        gig && en_reg |-> ing_wvalid
            && ing_wdata[pmi_pkg::ING_ERR_BIT] == er_reg;
    endproperty
    a_gig_push: assert property (p_gig_push)
        else $error("transmit byte or its error flag lost");

    c_gig_frame: cover property (@(posedge link_clk) disable iff (lrst)
        gig && en_reg ##1 en_reg ##1 !en_reg);
    c_nib_out: cover property (@(posedge link_clk) disable iff (lrst)
        s_first_nib ##1 egr_state_reg == pmi_pkg::EGR_SECOND);
    c_collision: cover property (@(posedge link_clk) disable iff (lrst)
        port_collision_o);
    c_overrun: cover property (@(posedge clk) disable iff (rst)
        $rose(core_overrun));
endmodule
